// File: design/mlc_dev.sv
`timescale 1ns/10ps
module mlc_dev #(
   parameter int RST_MIN = mlc_pkg::RST_MIN_CYC,
   parameter int INIT = mlc_pkg::INIT_CYC
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Pins toward the host
   mlc_if.dev pins,
   // Module side
   input wire logic fault_evt,
   output logic low_power_active,
   output logic data_not_ready,
   output logic [7:0] ctrl_byte
);
   import mlc_pkg::*;

   logic [4:0] s1_q, s2_q;
   logic [1:0] s3_q;
   logic sel_n_s, rstn_s, lp_s, scl_s, sda_s;
   logic scl_rise, scl_fall, start_c, stop_c, bus_ok;
   logic [15:0] rlow_q, init_q;
   logic hold_q, dnr_q, done_p, int_q, lp_q;
   logic [7:0] flags_q, rd_data, clr_mask;
   logic [7:0] map_q [MAP_WORDS];
   mlc_dst_t st_q;
   logic [7:0] sh_q;
   logic [3:0] cnt_q, ptr_q;
   logic rw_q, ptrph_q, drv_q, nack_q, wr_en, ld_en;

   //***********************************************
   // Pin synchronisers
   //***********************************************
   // all host pins synchronised
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         s1_q <= 5'h1b;
         s2_q <= 5'h1b;
         s3_q <= 2'h3;
      end else begin
         s1_q <= {pins.module_select_n, pins.module_reset_n,
                  pins.low_power_select, pins.scl_line, pins.sda_line};
         s2_q <= s1_q;
         s3_q <= s2_q[1:0];
      end
   end
   assign sel_n_s = s2_q[4];
   assign rstn_s = s2_q[3];
   assign lp_s = s2_q[2];
   assign scl_s = s2_q[1];
   assign sda_s = s2_q[0];

   // Bus conditions seen on the synchronised lines
   assign scl_rise = scl_s & ~s3_q[1];
   assign scl_fall = ~scl_s & s3_q[1];
   assign start_c = scl_s & s3_q[1] & s3_q[0] & ~sda_s;
   assign stop_c = scl_s & s3_q[1] & ~s3_q[0] & sda_s;
   assign bus_ok = ~sel_n_s & ~hold_q & ~start_c & ~stop_c;

   //***********************************************
   // Reset filter and start-up
   //***********************************************
   // count low time
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rlow_q <= 16'h0;
         hold_q <= 1'b0;
      end else if (rstn_s) begin
         rlow_q <= 16'h0;
         hold_q <= 1'b0;
      end else if (!hold_q) begin
         hold_q <= (rlow_q == 16'(RST_MIN - 1));
         rlow_q <= rlow_q + 16'h1;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         init_q <= 16'h0;
         dnr_q <= 1'b1;
      end else if (hold_q) begin
         init_q <= 16'h0;
         dnr_q <= 1'b1;
      end else if (dnr_q) begin
         dnr_q <= (init_q != 16'(INIT - 1));
         init_q <= init_q + 16'h1;
      end
   end
   assign done_p = dnr_q & ~hold_q & (init_q == 16'(INIT - 1));
   assign data_not_ready = dnr_q;

   //***********************************************
   // Memory map
   //***********************************************
   // Read view; status and flags are live state
   always_comb begin
      rd_data = 8'h00;
      if (ptr_q == OFS_ID) begin
         rd_data = ID_VALUE;
      end else if (ptr_q == OFS_STATUS) begin
         rd_data[DNR_BIT] = dnr_q;
      end else if (ptr_q == OFS_FLAGS) begin
         rd_data = flags_q;
      end else if (ptr_q >= OFS_WR_FIRST) begin
         rd_data = map_q[ptr_q];
      end
   end

   assign wr_en = scl_fall & bus_ok & (st_q == MLC_ST_WR) &
                  (cnt_q == 4'h8) & ~ptrph_q & (ptr_q >= OFS_WR_FIRST);
   assign ld_en = scl_fall & bus_ok &
                  (((st_q == MLC_ST_AACK) & rw_q) |
                   ((st_q == MLC_ST_RACK) & ~nack_q));
   assign clr_mask = (ld_en && ptr_q == OFS_FLAGS) ? flags_q : 8'h00;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < MAP_WORDS; i++) begin
            map_q[i] <= MAP_RST;
         end
      end else if (hold_q) begin
         for (int i = 0; i < MAP_WORDS; i++) begin
            map_q[i] <= MAP_RST;
         end
      end else if (wr_en) begin
         map_q[ptr_q] <= sh_q;
      end
   end
   assign ctrl_byte = map_q[OFS_CTRL];

   // Flags clear on read, only the bits read, so a new event survives
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         flags_q <= FLAGS_RST;
      end else if (hold_q) begin
         flags_q <= FLAGS_RST;
      end else begin
         flags_q <= flags_q & ~clr_mask;
         if (fault_evt) begin
            flags_q[FLG_FAULT] <= 1'b1;
         end
         if (done_p) begin
            flags_q[FLG_RSTDONE] <= 1'b1;
         end
      end
   end

   //***********************************************
   // Pin drivers
   //***********************************************
   // Low power is held during start-up as well
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         int_q <= 1'b0;
         lp_q <= 1'b1;
      end else begin
         int_q <= |flags_q;
         lp_q <= lp_s | map_q[OFS_CTRL][CTRL_LP_BIT] | dnr_q;
      end
   end
   assign low_power_active = lp_q;
   assign pins.int_o = 1'b0;
   assign pins.int_oe_n = ~int_q;
   assign pins.sda_dev_o = 1'b0;
   assign pins.sda_dev_oe_n = ~drv_q;
   assign pins.module_present_n = 1'b0;

   //***********************************************
   // Serial slave
   //***********************************************
   // No clock stretching; the host must honour its own bit timing
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         st_q <= MLC_ST_IDLE;
         sh_q <= 8'h00;
         cnt_q <= 4'h0;
         ptr_q <= 4'h0;
         rw_q <= 1'b0;
         ptrph_q <= 1'b0;
         drv_q <= 1'b0;
         nack_q <= 1'b0;
      end else if (sel_n_s || hold_q) begin
         st_q <= MLC_ST_IDLE;
         drv_q <= 1'b0;
      end else if (start_c) begin
         st_q <= MLC_ST_ADDR;
         cnt_q <= 4'h0;
         drv_q <= 1'b0;
      end else if (stop_c) begin
         st_q <= MLC_ST_IDLE;
         drv_q <= 1'b0;
      end else if (scl_rise) begin
         // Only the ack states and a start clear the count
         cnt_q <= cnt_q + 4'h1;
         nack_q <= sda_s;
         if (st_q == MLC_ST_ADDR || st_q == MLC_ST_WR) begin
            sh_q <= {sh_q[6:0], sda_s};
         end
      end else if (scl_fall) begin
         case (st_q)
            MLC_ST_ADDR: begin
               if (cnt_q == 4'h8 && sh_q[7:1] == DEV_ADDR) begin
                  st_q <= MLC_ST_AACK;
                  drv_q <= 1'b1;
                  rw_q <= sh_q[0];
                  ptrph_q <= ~sh_q[0];
               end else if (cnt_q == 4'h8) begin
                  st_q <= MLC_ST_IDLE;
               end
            end
            MLC_ST_AACK, MLC_ST_RACK: begin
               cnt_q <= 4'h0;
               if (ld_en) begin
                  sh_q <= rd_data;
                  drv_q <= ~rd_data[7];
                  ptr_q <= ptr_q + 4'h1;
                  st_q <= MLC_ST_RD;
               end else begin
                  drv_q <= 1'b0;
                  st_q <= (st_q == MLC_ST_AACK) ? MLC_ST_WR : MLC_ST_IDLE;
               end
            end
            MLC_ST_WR: begin
               if (cnt_q == 4'h8) begin
                  drv_q <= 1'b1;
                  st_q <= MLC_ST_WACK;
                  ptrph_q <= 1'b0;
                  ptr_q <= ptrph_q ? sh_q[3:0] : ptr_q + 4'h1;
               end
            end
            MLC_ST_WACK: begin
               drv_q <= 1'b0;
               cnt_q <= 4'h0;
               st_q <= MLC_ST_WR;
            end
            MLC_ST_RD: begin
               sh_q <= {sh_q[6:0], 1'b0};
               drv_q <= (cnt_q != 4'h8) & ~sh_q[6];
               if (cnt_q == 4'h8) begin
                  st_q <= MLC_ST_RACK;
               end
            end
            default: begin
               st_q <= MLC_ST_IDLE;
            end
         endcase
      end
   end
endmodule

// File: design/mlc_host.sv
`timescale 1ns/10ps
module mlc_host (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Pins toward the module
   mlc_if.host pins,
   // Command port
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic cmd_write,
   input wire logic [7:0] cmd_addr,
   input wire logic [7:0] cmd_wdata,
   output logic rsp_valid,
   output logic [7:0] rsp_rdata,
   output logic rsp_nack,
   // Board control and status
   input wire logic reset_req,
   input wire logic low_power_req,
   output logic module_present,
   output logic int_pending,
   output logic status_valid
);
   import mlc_pkg::*;

   //***********************************************
   // Input synchronisers
   //***********************************************
   logic [2:0] s1_q, s2_q;
   logic sda_s, int_n_s, prs_n_s;
   mlc_hst_t st_q;
   logic [2:0] s_q;
   logic [3:0] b_q;
   logic [1:0] ph_q;
   logic [15:0] qcnt_q, rcnt_q;
   logic wr_q, nack_q, scl_q, sda_q, sel_n_q, rstn_q, lp_q, wait_q;
   logic [7:0] addr_q, data_q, rd_q, bval;
   logic tick, last_bit;
   mlc_sym_t kind;

   // Two flops on every line coming from the module
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         s1_q <= 3'h7;
         s2_q <= 3'h7;
      end else begin
         s1_q <= {pins.sda_line, pins.int_line, pins.module_present_n};
         s2_q <= s1_q;
      end
   end
   assign sda_s = s2_q[2];
   assign int_n_s = s2_q[1];
   assign prs_n_s = s2_q[0];

   //***********************************************
   // Board pins
   //***********************************************
   // interrupt seen
   assign int_pending = ~int_n_s;
   assign module_present = ~prs_n_s;
   assign status_valid = ~wait_q;

   // Reset pulse; status is untrusted until the ready interrupt
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rcnt_q <= 16'h0;
         rstn_q <= 1'b1;
         wait_q <= 1'b1;
         lp_q <= 1'b0;
      end else begin
         lp_q <= low_power_req;
         rstn_q <= (rcnt_q == 16'h0);
         if (rcnt_q != 16'h0) begin
            rcnt_q <= rcnt_q - 16'h1;
         end else if (reset_req) begin
            rcnt_q <= 16'(RST_PULSE_CYC);
         end
         if (reset_req || rcnt_q != 16'h0) begin
            wait_q <= 1'b1;
         end else if (!int_n_s) begin
            wait_q <= 1'b0;
         end
      end
   end
   assign pins.module_reset_n = rstn_q;
   assign pins.low_power_select = lp_q;
   assign pins.module_select_n = sel_n_q;
   assign pins.scl_host_o = 1'b0;
   assign pins.sda_host_o = 1'b0;
   assign pins.scl_host_oe_n = scl_q;
   assign pins.sda_host_oe_n = sda_q;

   //***********************************************
   // Serial master sequencer
   //***********************************************
   assign cmd_ready = (st_q == MLC_H_IDLE);
   assign tick = (qcnt_q == 16'(QTR_CYC - 1));
   assign last_bit = (b_q == 4'h8);

   // Step program: write is S,A,P,D,stop; read is S,A,P,S,A,R,stop
   always_comb begin
      kind = MLC_SY_BYTE;
      if (s_q == 3'h0 || (!wr_q && s_q == 3'h3)) begin
         kind = MLC_SY_START;
      end else if (s_q == (wr_q ? 3'h4 : 3'h6)) begin
         kind = MLC_SY_STOP;
      end
      bval = 8'hff;
      if (s_q == 3'h1) begin
         bval = {DEV_ADDR, 1'b0};
      end else if (s_q == 3'h2) begin
         bval = addr_q;
      end else if (s_q == 3'h3 && wr_q) begin
         bval = data_q;
      end else if (s_q == 3'h4 && !wr_q) begin
         bval = {DEV_ADDR, 1'b1};
      end
   end

   // Line levels for the current quarter; acks are always released
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else if (st_q != MLC_H_RUN) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= (ph_q == 2'h1) || (ph_q == 2'h2) ||
                  (kind == MLC_SY_STOP && ph_q == 2'h3);
         if (kind == MLC_SY_START) begin
            sda_q <= ~ph_q[1];
         end else if (kind == MLC_SY_STOP) begin
            sda_q <= ph_q[1];
         end else begin
            sda_q <= last_bit | bval[3'(7 - b_q)];
         end
      end
   end

   // Command flow, quarter ticks and bit sampling
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         st_q <= MLC_H_IDLE;
         s_q <= 3'h0;
         b_q <= 4'h0;
         ph_q <= 2'h0;
         qcnt_q <= 16'h0;
         wr_q <= 1'b0;
         nack_q <= 1'b0;
         sel_n_q <= 1'b1;
         addr_q <= 8'h00;
         data_q <= 8'h00;
         rd_q <= 8'h00;
         rsp_valid <= 1'b0;
         rsp_rdata <= 8'h00;
         rsp_nack <= 1'b0;
      end else begin
         rsp_valid <= 1'b0;
         qcnt_q <= (tick || st_q == MLC_H_IDLE) ? 16'h0 : qcnt_q + 16'h1;
         case (st_q)
            MLC_H_IDLE: begin
               if (cmd_valid) begin
                  st_q <= MLC_H_SEL;
                  sel_n_q <= 1'b0;
                  wr_q <= cmd_write;
                  addr_q <= cmd_addr;
                  data_q <= cmd_wdata;
                  nack_q <= 1'b0;
                  s_q <= 3'h0;
                  b_q <= 4'h0;
                  ph_q <= 2'h0;
               end
            end
            // One quarter of select setup before the start
            MLC_H_SEL: begin
               if (tick) begin
                  st_q <= MLC_H_RUN;
               end
            end
            default: begin
               if (tick) begin
                  ph_q <= ph_q + 2'h1;
                  if (kind == MLC_SY_BYTE && ph_q == 2'h2) begin
                     if (!last_bit) begin
                        rd_q <= {rd_q[6:0], sda_s};
                     end else if (sda_s && (wr_q || s_q != 3'h5)) begin
                        nack_q <= 1'b1;
                     end
                  end
                  if (ph_q == 2'h3) begin
                     if (kind == MLC_SY_STOP) begin
                        st_q <= MLC_H_IDLE;
                        sel_n_q <= 1'b1;
                        rsp_valid <= 1'b1;
                        rsp_rdata <= rd_q;
                        rsp_nack <= nack_q;
                     end else if (kind == MLC_SY_START) begin
                        s_q <= s_q + 3'h1;
                     end else if (!last_bit) begin
                        b_q <= b_q + 4'h1;
                     end else begin
                        b_q <= 4'h0;
                        // A refused byte skips straight to the stop
                        s_q <= nack_q ? (wr_q ? 3'h4 : 3'h6) : s_q + 3'h1;
                     end
                  end
               end
            end
         endcase
      end
   end
endmodule

// File: design/mlc_if.sv
`timescale 1ns/10ps
interface mlc_if;
   // Plain pins
   logic module_select_n;
   logic module_reset_n;
   logic low_power_select;
   logic module_present_n;
   // Open-drain drivers, enable low means pulling
   logic scl_host_o;
   logic scl_host_oe_n;
   logic sda_host_o;
   logic sda_host_oe_n;
   logic sda_dev_o;
   logic sda_dev_oe_n;
   logic int_o;
   logic int_oe_n;
   // Resolved wire levels
   logic scl_line;
   logic sda_line;
   logic int_line;

   // Board pull-ups: a released wire reads high
   assign scl_line = scl_host_oe_n | scl_host_o;
   assign sda_line = (sda_host_oe_n | sda_host_o) &
                     (sda_dev_oe_n | sda_dev_o);
   assign int_line = int_oe_n | int_o;

   modport dev (
      input module_select_n, module_reset_n, low_power_select,
      input scl_line, sda_line,
      output sda_dev_o, sda_dev_oe_n, int_o, int_oe_n,
      output module_present_n
   );
   modport host (
      output module_select_n, module_reset_n, low_power_select,
      output scl_host_o, scl_host_oe_n, sda_host_o, sda_host_oe_n,
      input scl_line, sda_line, int_line, module_present_n
   );
endinterface

// File: design/mlc_pkg.sv
package mlc_pkg;

   //***********************************************
   // Clock and timing
   //***********************************************
   localparam int CLK_KHZ = 100000;
   localparam int SCL_KHZ = 100;
   // Quarter of one serial clock period, in mclk cycles
   localparam int QTR_CYC = CLK_KHZ / (SCL_KHZ * 4);
   // Shortest reset-input low level the module accepts
   localparam int RST_MIN_CYC = 16;
   // Reset pulse the host produces, longer than the minimum
   localparam int RST_PULSE_CYC = 64;
   // Internal start-up time before the module reports ready
   localparam int INIT_CYC = 32;

   //***********************************************
   // Serial bus and memory map
   //***********************************************
   localparam logic [6:0] DEV_ADDR = 7'h50;
   localparam int MAP_WORDS = 16;
   localparam logic [3:0] OFS_ID = 4'h0;
   localparam logic [3:0] OFS_STATUS = 4'h2;
   localparam logic [3:0] OFS_FLAGS = 4'h3;
   localparam logic [3:0] OFS_CTRL = 4'h4;
   localparam logic [3:0] OFS_WR_FIRST = 4'h4;
   // Identity byte, value arbitrary
   localparam logic [7:0] ID_VALUE = 8'h5a;
   localparam int DNR_BIT = 0;
   localparam int FLG_RSTDONE = 0;
   localparam int FLG_FAULT = 1;
   localparam int CTRL_LP_BIT = 0;
   localparam logic [7:0] MAP_RST = 8'h00;
   localparam logic [7:0] FLAGS_RST = 8'h00;

   //***********************************************
   // State types
   //***********************************************
   typedef enum logic [2:0] {
      MLC_ST_IDLE, MLC_ST_ADDR, MLC_ST_AACK, MLC_ST_WR,
      MLC_ST_WACK, MLC_ST_RD, MLC_ST_RACK
   } mlc_dst_t;
   typedef enum logic [1:0] {
      MLC_H_IDLE, MLC_H_SEL, MLC_H_RUN
   } mlc_hst_t;
   typedef enum logic [1:0] {
      MLC_SY_START, MLC_SY_BYTE, MLC_SY_STOP
   } mlc_sym_t;

endpackage

// File: tb/mlc_asserts.sv
`timescale 1ns/10ps
// Wire-level checks on the pins that join host and module ends
module mlc_asserts #(
   parameter int RST_MIN = mlc_pkg::RST_MIN_CYC,
   parameter int INIT = mlc_pkg::INIT_CYC
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Control pins
   input wire logic module_select_n,
   input wire logic module_reset_n,
   input wire logic module_present_n,
   // Open-drain lines
   input wire logic scl_host_oe_n,
   input wire logic sda_dev_oe_n,
   input wire logic int_o,
   input wire logic int_oe_n,
   input wire logic scl_line,
   input wire logic int_line
);
   import mlc_pkg::*;
   // Sync flops, filter, flag and interrupt registers, plus slack
   localparam int HOLD_CYC = RST_MIN + 6;
   localparam int DONE_MAX = INIT + 16;
   logic [7:0] low_cnt_q;

   //**********
   // Reset low-time counter
   //**********
   // Saturates so a long pulse never wraps below the limit
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         low_cnt_q <= 8'h00;
      end else if (module_reset_n) begin
         low_cnt_q <= 8'h00;
      end else if (low_cnt_q != 8'hff) begin
         low_cnt_q <= low_cnt_q + 8'h01;
      end
   end

   //**********
   // Properties
   //**********
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   AST_PRESENT_LOW: assert property (
      module_present_n == 1'b0) else $error("presence not low");
   AST_INT_PULL_ONLY: assert property (
      int_o == 1'b0) else $error("interrupt drives high");
   AST_INT_HELD: assert property (
      $rose(int_oe_n) |-> !module_select_n || !module_reset_n)
      else $error("interrupt released without a read or reset");
   AST_SEL_QUIET: assert property (
      module_select_n [*4] |-> sda_dev_oe_n)
      else $error("data driven while unselected");
   AST_SCL_NEEDS_SEL: assert property (
      !scl_host_oe_n |-> !module_select_n)
      else $error("clock pulled without select");
   AST_RST_PULSE_LONG: assert property (
      $fell(module_reset_n) |-> !module_reset_n [*8])
      else $error("reset pulse too short");
   AST_HOLD_QUIET: assert property (
      low_cnt_q >= HOLD_CYC |-> int_oe_n && sda_dev_oe_n)
      else $error("module active during held reset");
   AST_SOFT_DONE: assert property (
      $rose(module_reset_n) |-> ##[1:DONE_MAX] !int_oe_n)
      else $error("no completion interrupt after reset");
   AST_POWERUP_DONE: assert property (
      $fell(rst) |-> ##[1:DONE_MAX] !int_oe_n)
      else $error("no completion interrupt at power-up");
   AST_SDA_STILL: assert property (
      $past(scl_line) && scl_line |-> $stable(sda_dev_oe_n))
      else $error("data moved while clock high");
endmodule

// File: tb/tb.sv
`timescale 1ns/10ps
// Joins both ends and runs commands, resets and events
module tb;
   import mlc_pkg::*;
   typedef struct packed {
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
      logic [7:0] rdata;
   } mlc_row_t;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic cmd_valid = 1'b0;
   logic cmd_write = 1'b0;
   logic [7:0] cmd_addr = 8'h00;
   logic [7:0] cmd_wdata = 8'h00;
   logic reset_req = 1'b0;
   logic low_power_req = 1'b0;
   logic fault_evt = 1'b0;
   logic cmd_ready, rsp_valid, rsp_nack, module_present;
   logic int_pending, status_valid, low_power_active, data_not_ready;
   logic [7:0] rsp_rdata, ctrl_byte;
   int mismatches = 0;
   int n_checks = 0;
   mlc_row_t rows [2];

   // Free-running 100 MHz clock
   always #5 mclk = ~mclk;

   //**********
   // Both ends and the wire checker
   //**********
   mlc_if i_mlc_if ();
   mlc_host i_mlc_host (.mclk(mclk), .rst(rst), .pins(i_mlc_if),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
      .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
      .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_nack(rsp_nack),
      .reset_req(reset_req), .low_power_req(low_power_req),
      .module_present(module_present), .int_pending(int_pending),
      .status_valid(status_valid));
   // Short filter and start-up keep the reset scenarios brief
   mlc_dev #(.RST_MIN(4), .INIT(8)) i_mlc_dev (.mclk(mclk), .rst(rst),
      .pins(i_mlc_if), .fault_evt(fault_evt),
      .low_power_active(low_power_active),
      .data_not_ready(data_not_ready), .ctrl_byte(ctrl_byte));
   mlc_asserts #(.RST_MIN(4), .INIT(8)) i_mlc_asserts (.mclk(mclk),
      .rst(rst), .module_select_n(i_mlc_if.module_select_n),
      .module_reset_n(i_mlc_if.module_reset_n),
      .module_present_n(i_mlc_if.module_present_n),
      .scl_host_oe_n(i_mlc_if.scl_host_oe_n),
      .sda_dev_oe_n(i_mlc_if.sda_dev_oe_n), .int_o(i_mlc_if.int_o),
      .int_oe_n(i_mlc_if.int_oe_n), .scl_line(i_mlc_if.scl_line),
      .int_line(i_mlc_if.int_line));

   //**********
   // Shared tasks
   //**********
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(negedge mclk);
   endtask

   // Bounded wait at falling edges, so a stuck flag cannot hang the run
   task automatic wait_for(ref logic sig, input logic lvl, input int lim);
      for (int k = 0; k < lim && sig !== lvl; k++) @(negedge mclk);
   endtask

   task automatic run_cmd(input mlc_row_t r);
      @(negedge mclk);
      check({7'h00, cmd_ready}, 8'h01);
      cmd_valid = 1'b1;
      cmd_write = r.wr;
      cmd_addr = r.addr;
      cmd_wdata = r.wdata;
      @(negedge mclk);
      cmd_valid = 1'b0;
      wait_for(rsp_valid, 1'b1, 60000);
      check({7'h00, rsp_valid}, 8'h01);
      check({7'h00, rsp_nack}, 8'h00);
      if (!r.wr) check(rsp_rdata, r.rdata);
   endtask

   task automatic test_done();
      $display("checks=%0d mismatches=%0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   //**********
   // Main sequence
   //**********
   initial begin
      rows[0] = '{1'b1, {4'h0, OFS_CTRL}, 8'h01, 8'h00};
      rows[1] = '{1'b0, {4'h0, OFS_FLAGS}, 8'h00, 8'h01 << FLG_RSTDONE};
      repeat (20) @(posedge mclk);
      @(negedge mclk);
      rst = 1'b0;
      wait_for(status_valid, 1'b1, 200);
      tick(4);
      check({7'h00, status_valid}, 8'h01);
      check({7'h00, data_not_ready}, 8'h00);
      check({7'h00, int_pending}, 8'h01);
      check({7'h00, module_present}, 8'h01);
      check({7'h00, low_power_active}, 8'h00);
      foreach (rows[i]) run_cmd(rows[i]);
      tick(4);
      check(ctrl_byte, 8'h01);
      check({7'h00, low_power_active}, 8'h01);
      check({7'h00, int_pending}, 8'h00);
      fault_evt = 1'b1;
      tick(1);
      fault_evt = 1'b0;
      tick(8);
      check({7'h00, int_pending}, 8'h01);
      reset_req = 1'b1;
      tick(1);
      reset_req = 1'b0;
      wait_for(data_not_ready, 1'b1, 100);
      tick(2);
      check({7'h00, data_not_ready}, 8'h01);
      check(ctrl_byte, 8'h00);
      wait_for(data_not_ready, 1'b0, 300);
      wait_for(status_valid, 1'b1, 50);
      tick(4);
      check({7'h00, status_valid}, 8'h01);
      check({7'h00, int_pending}, 8'h01);
      check({7'h00, low_power_active}, 8'h00);
      low_power_req = 1'b1;
      tick(8);
      check({7'h00, low_power_active}, 8'h01);
      test_done();
   end

   // Two bus commands take about 69k cycles; allow 90k before giving up
   initial begin
      #900000;
      mismatches++;
      test_done();
   end
endmodule
